// file: hw/acs_ctrl.sv
// module: compare, status, calibration and dma monitor slice of the converter
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - two units compare 12-bit threshold
// - match counter sets flag at target+1
// - channel field picks compared result
// - condition one: ge; zero: less than
// - flag with irq enable raises request
// - compare only when enabled, on load
// - signed compare when signed format set
// - status shows overrun flags 23:16
// - status shows valid flags 15:8
// - channel field: registered next channel
// - busy mirrors conversion run bit
// - compare flag cleared by writing one
// - end flag on single/scan end, w1c
// - calibration completes after 127 converter clocks
// - clearing enable stops, clears complete
// - monitor returns last word captured while dma active
// - valid set on load, cleared on read
// - overrun on overwrite, cleared on read
// - run bit self-clears except continuous
module acs_ctrl
   import acs_pkg::*;
#(
   parameter int NUM_CH = 8
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // converter core side
   input  wire acs_result_t       result_in,
   input  wire logic [NUM_CH-1:0] result_read,
   input  wire logic [2:0]        next_channel,
   input  wire logic              adc_clk_tick,
   input  wire logic              dma_active,
   input  wire logic [11:0]       dma_word,
   // control outputs
   output logic                   conversion_run,
   output logic [1:0]             conv_mode,
   output logic                   signed_result_format,
   output logic                   cal_running,
   output logic                   compare_irq
);

   // =========================================================
   // state
   logic [31:0]       cmp0_reg;
   logic [31:0]       cmp1_reg;
   logic [3:0]        cnt0_reg;
   logic [3:0]        cnt1_reg;
   logic              flag0_reg;
   logic              flag1_reg;
   logic              end_reg;
   logic [NUM_CH-1:0] valid_reg;
   logic [NUM_CH-1:0] ovr_reg;
   logic [2:0]        chan_reg;
   logic              cal_en_reg;
   logic              cal_done_reg;
   logic [6:0]        cal_cnt_reg;
   logic [11:0]       mon_reg;
   logic [31:0]       rdata_next;
   logic              wr_acc;
   logic              rd_acc;
   logic              hit0;
   logic              hit1;
   logic              set0;
   logic              set1;
   acs_cmp_cfg_t      cfg0;
   acs_cmp_cfg_t      cfg1;

   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;

   // =========================================================
   // compare helpers
   function automatic acs_cmp_cfg_t unpack_cfg(input logic [31:0] w);
      acs_cmp_cfg_t c;
      c.threshold    = w[CMP_THR_MSB:CMP_THR_LSB];
      c.match_target = w[CMP_CNT_MSB:CMP_CNT_LSB];
      c.channel      = w[CMP_CH_MSB:CMP_CH_LSB];
      c.cond_ge      = w[CMP_COND_BIT];
      c.irq_en       = w[CMP_IE_BIT];
      c.enable       = w[CMP_EN_BIT];
      return c;
   endfunction

   function automatic logic match_of(input acs_cmp_cfg_t c, input logic [11:0] d,
                                     input logic sgn);
      logic ge;
      if (sgn) begin
         ge = $signed(d) >= $signed(c.threshold);
      end else begin
         ge = d >= c.threshold;
      end
      return c.cond_ge ? ge : !ge;
   endfunction

   assign cfg0 = unpack_cfg(cmp0_reg);
   assign cfg1 = unpack_cfg(cmp1_reg);

   assign hit0 = result_in.load && cfg0.enable && (result_in.channel == cfg0.channel)
                 && match_of(cfg0, result_in.data, signed_result_format);
   assign hit1 = result_in.load && cfg1.enable && (result_in.channel == cfg1.channel)
                 && match_of(cfg1, result_in.data, signed_result_format);
   assign set0 = hit0 && (cnt0_reg == cfg0.match_target);
   assign set1 = hit1 && (cnt1_reg == cfg1.match_target);

   // =========================================================
   // compare registers
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cmp0_reg <= RESET_WORD;
         cmp1_reg <= RESET_WORD;
      end else if (wr_acc && paddr == OFS_CMP_ZERO) begin
         cmp0_reg <= pwdata & 32'h0fff_0f3f;
      end else if (wr_acc && paddr == OFS_CMP_ONE) begin
         cmp1_reg <= pwdata & 32'h0fff_0f3f;
      end
   end

   // match counters restart after each flag event
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt0_reg <= 4'h0;
         cnt1_reg <= 4'h0;
      end else begin
         if (set0) cnt0_reg <= 4'h0;
         else if (hit0) cnt0_reg <= cnt0_reg + 4'h1;
         if (set1) cnt1_reg <= 4'h0;
         else if (hit1) cnt1_reg <= cnt1_reg + 4'h1;
      end
   end

   // =========================================================
   // sticky flags: set wins over a same-cycle clear
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         flag0_reg <= 1'b0;
         flag1_reg <= 1'b0;
         end_reg   <= 1'b0;
      end else begin
         if (set0) flag0_reg <= 1'b1;
         else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_COMPARE_FLAG_ZERO_BIT]) flag0_reg <= 1'b0;
         if (set1) flag1_reg <= 1'b1;
         else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_COMPARE_FLAG_ONE_BIT]) flag1_reg <= 1'b0;
         // end of single or full scan
         if (result_in.load && result_in.cycle_end) end_reg <= 1'b1;
         else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_END_BIT]) end_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) compare_irq <= 1'b0;
      else compare_irq <= (flag0_reg && cfg0.irq_en) || (flag1_reg && cfg1.irq_en);
   end

   // =========================================================
   // per-channel valid and overrun
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         valid_reg <= '0;
         ovr_reg   <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (result_in.load && result_in.channel == i[2:0]) begin
               // load sets valid, overwrite sets overrun
               valid_reg[i] <= 1'b1;
               ovr_reg[i]   <= valid_reg[i] && !result_read[i] ? 1'b1 : ovr_reg[i];
            end else if (result_read[i]) begin
               valid_reg[i] <= 1'b0;
               ovr_reg[i]   <= 1'b0;
            end
         end
      end
   end

   // =========================================================
   // run control, mode and format
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         conversion_run       <= 1'b0;
         conv_mode            <= ACS_MODE_SINGLE;
         signed_result_format <= 1'b0;
      end else if (wr_acc && paddr == OFS_RUN_CTRL) begin
         conversion_run       <= pwdata[RUN_BIT];
         conv_mode            <= pwdata[MODE_LSB+1:MODE_LSB];
         signed_result_format <= pwdata[SIGNED_BIT];
      end else if (result_in.load && result_in.cycle_end
                   && conv_mode != ACS_MODE_SCANC) begin
         conversion_run <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) chan_reg <= 3'h0;
      else chan_reg <= next_channel;
   end

   // =========================================================
   // calibration counts converter clock ticks
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cal_en_reg   <= 1'b0;
         cal_done_reg <= 1'b0;
         cal_cnt_reg  <= 7'h00;
      end else if (wr_acc && paddr == OFS_CAL) begin
         cal_en_reg <= pwdata[CAL_EN_BIT];
         if (!pwdata[CAL_EN_BIT]) begin
            cal_done_reg <= 1'b0;
            cal_cnt_reg  <= 7'h00;
         end
      end else if (cal_en_reg && !cal_done_reg && adc_clk_tick) begin
         if (cal_cnt_reg == 7'(CAL_CLOCKS - 1)) cal_done_reg <= 1'b1;
         cal_cnt_reg <= cal_cnt_reg + 7'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) cal_running <= 1'b0;
      else cal_running <= cal_en_reg && !cal_done_reg;
   end

   // capture word on the dma path
   always_ff @(posedge ref_clk) begin
      if (!resetn) mon_reg <= 12'h000;
      else if (dma_active) mon_reg <= dma_word;
   end

   // =========================================================
   // read mux, registered during setup phase
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (paddr == OFS_CMP_ZERO) begin
         rdata_next = cmp0_reg;
      end else if (paddr == OFS_CMP_ONE) begin
         rdata_next = cmp1_reg;
      end else if (paddr == OFS_STATUS) begin
         rdata_next[ST_OVR_LSB +: 8]   = ovr_reg;
         rdata_next[ST_VALID_LSB +: 8] = valid_reg;
         rdata_next[ST_CHAN_LSB +: 3]  = chan_reg;
         rdata_next[ST_BUSY_BIT]       = conversion_run;
         rdata_next[ST_COMPARE_FLAG_ONE_BIT]      = flag1_reg;
         rdata_next[ST_COMPARE_FLAG_ZERO_BIT]      = flag0_reg;
         rdata_next[ST_END_BIT]        = end_reg;
      end else if (paddr == OFS_CAL) begin
         rdata_next[CAL_EN_BIT]   = cal_en_reg;
         rdata_next[CAL_DONE_BIT] = cal_done_reg;
      end else if (paddr == OFS_DMA_MON) begin
         rdata_next[11:0] = mon_reg;
      end else if (paddr == OFS_RUN_CTRL) begin
         rdata_next[RUN_BIT]                = conversion_run;
         rdata_next[MODE_LSB+1:MODE_LSB]    = conv_mode;
         rdata_next[SIGNED_BIT]             = signed_result_format;
      end
   end

   // zero wait states; read data flop-driven from the setup phase
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (rd_acc) prdata <= rdata_next;
         pready  <= psel && !penable;
         pslverr <= 1'b0;
      end
   end

   // =========================================================
   // checks
   // compare units
   a_flag_sets_on_hit: assert property (@(posedge ref_clk) disable iff (!resetn)
      set0 |=> flag0_reg) else $error("flag zero missed its set");
   a_flag_one_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
      set1 |=> flag1_reg) else $error("flag one missed its set");
   a_cnt_counts_hit: assert property (@(posedge ref_clk) disable iff (!resetn)
      hit0 && !set0 |=> cnt0_reg == $past(cnt0_reg) + 4'h1)
      else $error("match counter missed a hit");
   a_flag_holds_zero_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      flag1_reg && !(wr_acc && paddr == OFS_STATUS && pwdata[ST_COMPARE_FLAG_ONE_BIT]) |=> flag1_reg)
      else $error("flag one lost without clear");
   a_flag_clear_one: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_acc && paddr == OFS_STATUS && pwdata[ST_COMPARE_FLAG_ZERO_BIT] && !set0 |=> !flag0_reg)
      else $error("flag zero not cleared");
   a_irq_follows_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
      set0 && cfg0.irq_en && !wr_acc |=> ##1 compare_irq) else $error("irq missing");
   a_irq_needs_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
      !cfg0.irq_en && !cfg1.irq_en |=> !compare_irq) else $error("irq while masked");
   a_no_hit_disabled: assert property (@(posedge ref_clk) disable iff (!resetn)
      !cfg0.enable |=> !$rose(flag0_reg) && $stable(cnt0_reg))
      else $error("compare while disabled");
   a_other_channel: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_in.load && result_in.channel != cfg0.channel |=> $stable(cnt0_reg))
      else $error("wrong channel counted");
   a_ge_sets_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_in.load && cfg0.enable && result_in.channel == cfg0.channel && cfg0.cond_ge
      && cnt0_reg == cfg0.match_target && !signed_result_format
      && result_in.data >= cfg0.threshold |=> flag0_reg) else $error("ge match missed");
   a_less_sets_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_in.load && cfg1.enable && result_in.channel == cfg1.channel && !cfg1.cond_ge
      && cnt1_reg == cfg1.match_target && !signed_result_format
      && result_in.data < cfg1.threshold |=> flag1_reg) else $error("less match missed");
   a_signed_sets_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_in.load && cfg1.enable && result_in.channel == cfg1.channel && !cfg1.cond_ge
      && cnt1_reg == cfg1.match_target && signed_result_format
      && $signed(result_in.data) < $signed(cfg1.threshold) |=> flag1_reg)
      else $error("signed match missed");
   // status and run
   a_end_flag_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_in.load && result_in.cycle_end |=> end_reg) else $error("end flag missed");
   a_end_flag_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_acc && paddr == OFS_STATUS && pwdata[ST_END_BIT] && !result_in.load |=> !end_reg)
      else $error("end flag not cleared");
   a_busy_mirror: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_acc && paddr == OFS_STATUS |=> prdata[ST_BUSY_BIT] == $past(conversion_run))
      else $error("busy not mirrored");
   a_valid_mirror: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_acc && paddr == OFS_STATUS |=> prdata[ST_VALID_LSB +: 8] == $past(valid_reg))
      else $error("valid not mirrored");
   a_chan_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
      resetn |=> chan_reg == $past(next_channel)) else $error("channel field stale");
   a_valid_on_load: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_in.load |=> valid_reg[$past(result_in.channel)])
      else $error("valid not set");
   a_run_self_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_in.load && result_in.cycle_end && conv_mode == ACS_MODE_SINGLE && !wr_acc
      |=> !conversion_run) else $error("run not cleared");
   a_scan_keeps_run: assert property (@(posedge ref_clk) disable iff (!resetn)
      conversion_run && conv_mode == ACS_MODE_SCANC && !wr_acc |=> conversion_run)
      else $error("continuous run dropped");
   a_ovr_on_overwrite: assert property (@(posedge ref_clk) disable iff (!resetn)
      result_in.load && valid_reg[result_in.channel] && !result_read[result_in.channel]
      |=> ovr_reg[$past(result_in.channel)]) else $error("overrun missed");
   // calibration and monitor
   a_cal_drop_done: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_acc && paddr == OFS_CAL && !pwdata[CAL_EN_BIT] |=> !cal_done_reg)
      else $error("complete not cleared");
   a_cal_not_early: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(cal_done_reg) |-> $past(cal_cnt_reg) == 7'(CAL_CLOCKS - 1))
      else $error("calibration ended early");
   a_cal_counts: assert property (@(posedge ref_clk) disable iff (!resetn)
      cal_en_reg && !cal_done_reg && adc_clk_tick && !(wr_acc && paddr == OFS_CAL)
      |=> cal_cnt_reg == $past(cal_cnt_reg) + 7'h01) else $error("tick not counted");
   a_mon_capture: assert property (@(posedge ref_clk) disable iff (!resetn)
      dma_active |=> mon_reg == $past(dma_word)) else $error("dma word not captured");

endmodule

`default_nettype wire

// file: hw/acs_pkg.sv
// package: register map, field positions and shared types for the converter control slice
package acs_pkg;

   // =========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CMP_ZERO = 8'h28;
   localparam logic [7:0] OFS_CMP_ONE  = 8'h2c;
   localparam logic [7:0] OFS_STATUS   = 8'h30;
   localparam logic [7:0] OFS_CAL      = 8'h34;
   localparam logic [7:0] OFS_DMA_MON  = 8'h40;
   localparam logic [7:0] OFS_RUN_CTRL = 8'h44;

   // =========================================================
   // compare register fields
   localparam int CMP_THR_LSB   = 16;
   localparam int CMP_THR_MSB   = 27;
   localparam int CMP_CNT_LSB   = 8;
   localparam int CMP_CNT_MSB   = 11;
   localparam int CMP_CH_LSB    = 3;
   localparam int CMP_CH_MSB    = 5;
   localparam int CMP_COND_BIT  = 2;
   localparam int CMP_IE_BIT    = 1;
   localparam int CMP_EN_BIT    = 0;

   // =========================================================
   // status register fields
   localparam int ST_OVR_LSB    = 16;
   localparam int ST_VALID_LSB  = 8;
   localparam int ST_CHAN_LSB   = 4;
   localparam int ST_BUSY_BIT   = 3;
   localparam int ST_COMPARE_FLAG_ONE_BIT  = 2;
   localparam int ST_COMPARE_FLAG_ZERO_BIT  = 1;
   localparam int ST_END_BIT    = 0;

   // =========================================================
   // calibration fields and timing
   localparam int CAL_EN_BIT    = 0;
   localparam int CAL_DONE_BIT  = 1;
   localparam int CAL_CLOCKS    = 127;

   // run control fields
   localparam int RUN_BIT       = 0;
   localparam int MODE_LSB      = 1;
   localparam int SIGNED_BIT    = 3;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // =========================================================
   // converter operating modes
   typedef enum logic [1:0] {
      ACS_MODE_SINGLE = 2'b00,
      ACS_MODE_RSVD   = 2'b01,
      ACS_MODE_SCAN1  = 2'b10,
      ACS_MODE_SCANC  = 2'b11
   } acs_mode_t;

   // one compare unit's programmed settings
   typedef struct packed {
      logic [11:0] threshold;
      logic [3:0]  match_target;
      logic [2:0]  channel;
      logic        cond_ge;
      logic        irq_en;
      logic        enable;
   } acs_cmp_cfg_t;

   // a result loaded by the converter core
   typedef struct packed {
      logic        load;
      logic [2:0]  channel;
      logic [11:0] data;
      logic        cycle_end;
   } acs_result_t;

endpackage

// file: tb/acs_core_model.sv
// stand-in for the converter core and dma engine feeding the slice
`timescale 1ns/100ps
`default_nettype none
module acs_core_model
   import acs_pkg::*;
(
   // clock
   input  wire logic   ref_clk,
   // core-side outputs
   output acs_result_t result_in,
   output logic [7:0]  result_read,
   output logic [2:0]  next_channel,
   output logic        adc_clk_tick,
   output logic        dma_active,
   output logic [11:0] dma_word
);
   // =========================================================
   // idle levels
   initial begin
      result_in    = '0;
      result_read  = '0;
      next_channel = '0;
      adc_clk_tick = 1'b0;
      dma_active   = 1'b0;
      dma_word     = 12'hfff;
   end
   // =========================================================
   // result loads; idle data inverted so stale values never match
   task automatic load(input logic [2:0] ch, input logic [11:0] d, input logic e);
      @(posedge ref_clk);
      result_in <= {1'b1, ch, d, e};
      @(posedge ref_clk);
      result_in <= {1'b0, ~ch, ~d, 1'b0};
   endtask
   task automatic rd(input logic [7:0] m);
      @(posedge ref_clk);
      result_read <= m;
      @(posedge ref_clk);
      result_read <= '0;
   endtask
   task automatic set_next(input logic [2:0] c);
      @(posedge ref_clk);
      next_channel <= c;
   endtask
   // =========================================================
   // converter clock pulses, gap gives a slow converter
   task automatic ticks(input int n, input int gap);
      repeat (n) begin
         @(posedge ref_clk);
         adc_clk_tick <= 1'b1;
         @(posedge ref_clk);
         adc_clk_tick <= 1'b0;
         repeat (gap) @(posedge ref_clk);
      end
   endtask
   task automatic dma(input logic act, input logic [11:0] w);
      @(posedge ref_clk);
      dma_active <= act;
      dma_word   <= act ? w : ~w;
   endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the converter control slice
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import acs_pkg::*;
;
   // =========================================================
   // signals
   logic        ref_clk;
   logic        resetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   acs_result_t result_in;
   logic [7:0]  result_read;
   logic [2:0]  next_channel;
   logic        adc_clk_tick;
   logic        dma_active;
   logic [11:0] dma_word;
   logic        conversion_run;
   logic [1:0]  conv_mode;
   logic        signed_result_format;
   logic        cal_running;
   logic        compare_irq;
   logic [31:0] rd;
   int          n_errors;
   int          checks_done;

   acs_ctrl acs_ctrl_i (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .result_in(result_in), .result_read(result_read),
      .next_channel(next_channel), .adc_clk_tick(adc_clk_tick), .dma_active(dma_active),
      .dma_word(dma_word), .conversion_run(conversion_run), .conv_mode(conv_mode),
      .signed_result_format(signed_result_format), .cal_running(cal_running),
      .compare_irq(compare_irq));
   acs_core_model acs_core_model_i (.ref_clk(ref_clk), .result_in(result_in),
      .result_read(result_read), .next_channel(next_channel), .adc_clk_tick(adc_clk_tick),
      .dma_active(dma_active), .dma_word(dma_word));

   // =========================================================
   // shared tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // no wait limit here: the watchdog ends a hung transfer
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1);
      chk("pready wait", 32'h1, 32'(n));
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(w, e, rd & m);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // =========================================================
   // scenarios
   task automatic t_regs;
      logic [7:0] ofs [5] = '{OFS_CMP_ZERO, OFS_CMP_ONE, OFS_STATUS, OFS_CAL, OFS_DMA_MON};
      foreach (ofs[i]) rchk("reset value", ofs[i], '1, '0);
      apb(1'b1, 8'h3c, 32'hffff_ffff);
      rchk("unmapped", 8'h3c, '1, '0);
      apb(1'b1, OFS_CMP_ZERO, 32'hffff_ffff);
      rchk("cmp0 bits", OFS_CMP_ZERO, '1, 32'h0fff_0f3f);
      chk("pslverr", 32'h0, {31'h0, pslverr});
      apb(1'b1, OFS_CMP_ZERO, 32'h0);
   endtask
   task automatic t_cmp0;
      apb(1'b1, OFS_CMP_ZERO, 32'h0100_011f);
      acs_core_model_i.load(3'd3, 12'h100, 1'b0);
      acs_core_model_i.load(3'd2, 12'hfff, 1'b0);
      acs_core_model_i.load(3'd3, 12'h0ff, 1'b0);
      rchk("cmp0 early", OFS_STATUS, 32'h2, 32'h0);
      acs_core_model_i.load(3'd3, 12'h100, 1'b0);
      rchk("cmp0 flag", OFS_STATUS, 32'h2, 32'h2);
      chk("cmp0 irq", 32'h1, {31'h0, compare_irq});
      apb(1'b1, OFS_STATUS, 32'h0);
      rchk("cmp0 kept", OFS_STATUS, 32'h2, 32'h2);
      apb(1'b1, OFS_STATUS, 32'h2);
      rchk("cmp0 clear", OFS_STATUS, 32'h2, 32'h0);
      chk("irq clear", 32'h0, {31'h0, compare_irq});
      apb(1'b1, OFS_CMP_ZERO, 32'h0);
   endtask
   task automatic t_cmp1;
      apb(1'b1, OFS_CMP_ONE, 32'h0800_0008);
      acs_core_model_i.load(3'd1, 12'h100, 1'b0);
      rchk("cmp1 off", OFS_STATUS, 32'h4, 32'h0);
      apb(1'b1, OFS_CMP_ONE, 32'h0800_0009);
      acs_core_model_i.load(3'd1, 12'h800, 1'b0);
      rchk("cmp1 equal", OFS_STATUS, 32'h4, 32'h0);
      acs_core_model_i.load(3'd1, 12'h7ff, 1'b0);
      rchk("cmp1 less", OFS_STATUS, 32'h4, 32'h4);
      chk("irq masked", 32'h0, {31'h0, compare_irq});
      apb(1'b1, OFS_STATUS, 32'h4);
      // negative result against zero threshold only matches as signed
      apb(1'b1, OFS_RUN_CTRL, 32'h8);
      @(negedge ref_clk);
      chk("signed fmt", 32'h1, {31'h0, signed_result_format});
      apb(1'b1, OFS_CMP_ONE, 32'h0000_0009);
      acs_core_model_i.load(3'd1, 12'h800, 1'b0);
      rchk("cmp1 signed", OFS_STATUS, 32'h4, 32'h4);
      apb(1'b1, OFS_STATUS, 32'h4);
      apb(1'b1, OFS_RUN_CTRL, 32'h0);
      apb(1'b1, OFS_CMP_ONE, 32'h0);
   endtask
   task automatic t_flags;
      acs_core_model_i.rd(8'hff);
      acs_core_model_i.load(3'd5, 12'h321, 1'b0);
      rchk("valid", OFS_STATUS, 32'h00ff_ff00, 32'h0000_2000);
      acs_core_model_i.load(3'd5, 12'h322, 1'b0);
      rchk("overrun", OFS_STATUS, 32'h00ff_ff00, 32'h0020_2000);
      acs_core_model_i.rd(8'h20);
      rchk("read clears", OFS_STATUS, 32'h00ff_ff00, 32'h0);
   endtask
   task automatic t_run;
      acs_core_model_i.set_next(3'd6);
      apb(1'b1, OFS_RUN_CTRL, 32'h1);
      rchk("busy chan", OFS_STATUS, 32'h78, 32'h68);
      chk("run", 32'h1, {31'h0, conversion_run});
      acs_core_model_i.load(3'd0, 12'h123, 1'b1);
      rchk("single end", OFS_STATUS, 32'h79, 32'h61);
      apb(1'b1, OFS_STATUS, 32'h1);
      rchk("end clear", OFS_STATUS, 32'h1, 32'h0);
      apb(1'b1, OFS_RUN_CTRL, 32'h5);
      acs_core_model_i.load(3'd0, 12'h125, 1'b1);
      rchk("scan once end", OFS_STATUS, 32'h9, 32'h1);
      apb(1'b1, OFS_RUN_CTRL, 32'h7);
      acs_core_model_i.load(3'd0, 12'h124, 1'b1);
      chk("continuous", 32'h7, {29'h0, conv_mode, conversion_run});
      rchk("scan end", OFS_STATUS, 32'h9, 32'h9);
      apb(1'b1, OFS_RUN_CTRL, 32'h0);
      acs_core_model_i.set_next(3'd2);
      rchk("next chan", OFS_STATUS, 32'h78, 32'h20);
      apb(1'b1, OFS_STATUS, 32'h1);
   endtask
   task automatic t_cal;
      apb(1'b1, OFS_CAL, 32'h1);
      acs_core_model_i.ticks(126, 1);
      rchk("cal 126", OFS_CAL, 32'h3, 32'h1);
      chk("cal running", 32'h1, {31'h0, cal_running});
      acs_core_model_i.ticks(1, 3);
      rchk("cal 127", OFS_CAL, 32'h3, 32'h3);
      chk("cal idle", 32'h0, {31'h0, cal_running});
      apb(1'b1, OFS_CAL, 32'h1);
      rchk("cal kept", OFS_CAL, 32'h3, 32'h3);
      apb(1'b1, OFS_CAL, 32'h0);
      rchk("cal stop", OFS_CAL, 32'h3, 32'h0);
   endtask
   task automatic t_dma;
      acs_core_model_i.dma(1'b1, 12'habc);
      rchk("dma mon", OFS_DMA_MON, '1, 32'habc);
      acs_core_model_i.dma(1'b1, 12'h5a3);
      rchk("dma mon", OFS_DMA_MON, '1, 32'h5a3);
      acs_core_model_i.dma(1'b0, 12'h5a3);
   endtask

   // =========================================================
   // clock, reset, sequence and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("watchdog expired");
      wrap_up();
   end
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_errors = 0;
      checks_done = 0;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs();
      t_cmp0();
      t_cmp1();
      t_flags();
      t_run();
      t_cal();
      t_dma();
      wrap_up();
   end
endmodule
`default_nettype wire
